//--- verilog/fsl_pkg.sv
// Shared constants for the serial nonvolatile memory slave front end.
// Assumes a single system clock domain; all bus pins are sampled in it.
package fsl_pkg;

    // Array geometry
    localparam int          DATA_W    = 8;
    localparam int          ADDR_W    = 13;
    localparam int          MEM_DEPTH = 8192;
    localparam int          AHI_W     = ADDR_W - DATA_W;
    localparam logic [12:0] ADDR_MAX  = 13'h1FFF;
    localparam logic [12:0] ADDR_ZERO = 13'h0000;
    localparam logic [12:0] ADDR_ONE  = 13'h0001;

    // Slave address byte layout
    localparam int TYPE_W  = 4;
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int SEL_W   = 3;
    localparam int SEL_HI  = 3;
    localparam int SEL_LO  = 1;
    localparam int RW_BIT  = 0;

    // Bit counting within a byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_ONE       = 4'h1;

    // Transfer phase of the serial engine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } fsl_state_e;

    // Which byte of a write sequence is being received
    typedef enum logic [1:0] {
        K_DEV,
        K_AHI,
        K_ALO,
        K_DATA
    } fsl_kind_e;

endpackage : fsl_pkg

//--- verilog/fsl_fram_slave.sv
// Two-wire serial slave with an 8K x 8 byte array behind it.
// Assumes the bench resolves the open-drain data wire from sda_oe_n
// and models the pad pull-downs on the select and protect pins.
//
// Operation
// R1 - Answer only when address select bits equal the select pins.
// R2 - Unconnected select pins read low through internal pull-downs.
// R3 - Data line is open-drain: pulled low or released, never driven high.
// R4 - Sample incoming bits on clock rise, change outgoing bits on fall.
// R5 - Protect pin high blocks all array writes; low allows them.
// R6 - Unconnected protect pin reads low, so writes stay enabled.
// R7 - Array holds 8192 locations of eight bits each.
// R8 - Two address bytes follow the slave address; 13 bits pick one byte.
// R9 - Top three bits of the received 16-bit address are ignored.
// R10 - Each received data byte is written at once, no internal delay.
// R11 - Ready for a new transaction right after a write; no polling.
// R12 - Works at clock rates up to 1 MHz and at 100/400 kHz.
// R13 - Fixed device-type field tells this memory from other devices.
// R14 - Eight bits shift serially, one per clock, in and out.
// R15 - Address byte: type in 7-4, select in 3-1, bit 0 read high.
// R16 - Address latch advances per byte and wraps 1FFFh to 0000h.
// R17 - Read continues on master acknowledge, ends on its absence.
// R18 - Stop condition aborts any operation and waits for start.
// R19 - Protected writes still acknowledge and advance the address.
module fsl_fram_slave
    import fsl_pkg::*;
#(
    parameter logic [TYPE_W-1:0] DEV_TYPE = 4'h5 // Arbitrary type code
) (
    input  wire logic             mclk,               // System clock
    input  wire logic             rst_n,              // Async reset
    input  wire logic             scl,                // Serial clock pin
    input  wire logic             sda_in,             // Data wire level
    output logic                  sda_out,            // Data drive value
    output logic                  sda_oe_n,           // Low pulls wire
    input  wire logic [SEL_W-1:0] device_select_pins, // Select straps
    input  wire logic             wp,                 // Write protect
    output logic                  bus_active          // Transfer running
);

    // Synchroniser stages and edge history
    logic             scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic             sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic [SEL_W-1:0] sel_s1_ff, sel_s2_ff;
    logic             wp_s1_ff, wp_s2_ff;

    // Serial engine state
    fsl_state_e       state_ff;
    fsl_kind_e        kind_ff;
    logic [3:0]       bitcnt_ff;
    logic [7:0]       shreg_ff;
    logic [7:0]       txreg_ff;
    logic             rw_ff;
    logic             mack_ff;
    logic             oe_n_ff;

    // Address latch and array
    logic [ADDR_W-1:0] addr_ff;
    logic [AHI_W-1:0]  ahi_ff;
    logic [7:0]        mem_ff [0:MEM_DEPTH-1];

    // Decoded events
    logic              scl_rise, scl_fall;
    logic              start_det, stop_det;
    logic              byte_done, sel_match;
    logic              commit, mem_we, load_tx;
    logic              addr_inc, drv_event;
    logic [ADDR_W-1:0] nxt_addr;
    logic [7:0]        mem_rd;

    // Two sync flops and an edge flop per bus pin; 125 MHz gives over 60 samples per
    // half period even at the fastest bus rate [R12]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_s1_ff <= scl;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    // Straps; a floating pin arrives low via the pad pull-down [R2] [R6]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1_ff <= 3'h0;
            sel_s2_ff <= 3'h0;
            wp_s1_ff  <= 1'b0;
            wp_s2_ff  <= 1'b0;
        end else begin
            sel_s1_ff <= device_select_pins;
            sel_s2_ff <= sel_s1_ff;
            wp_s1_ff  <= wp;
            wp_s2_ff  <= wp_s1_ff;
        end
    end

    // Bus conditions, all seen from the second flop onward
    assign scl_rise  = scl_s2_ff & ~scl_d_ff;
    assign scl_fall  = ~scl_s2_ff & scl_d_ff;
    assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    assign stop_det  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

    // Byte boundary and address match
    assign byte_done = scl_fall && (state_ff == ST_RX)
                       && (bitcnt_ff == BITS_PER_BYTE);
    assign sel_match = (shreg_ff[TYPE_HI:TYPE_LO] == DEV_TYPE)    // [R13] [R15]
                       && (shreg_ff[SEL_HI:SEL_LO] == sel_s2_ff); // [R1]

    // Write commit and read load points
    assign commit   = byte_done && (kind_ff == K_DATA);          // [R10]
    assign mem_we   = commit && !wp_s2_ff;                       // [R5]
    assign load_tx  = scl_fall
                      && (((state_ff == ST_RX_ACK) && (kind_ff == K_DEV)
                           && rw_ff)
                          || ((state_ff == ST_TX_ACK) && mack_ff)); // [R17]
    assign addr_inc = commit || load_tx;                          // [R19]
    assign mem_rd   = mem_ff[addr_ff];

    // Wrap is explicit so the latch never leaves the array [R16]
    assign nxt_addr = (addr_ff == ADDR_MAX) ? ADDR_ZERO : addr_ff + ADDR_ONE;

    // Only ever pull low; the high level comes from the pull-up [R3]
    assign sda_out    = 1'b0;
    assign sda_oe_n   = oe_n_ff;
    assign bus_active = (state_ff != ST_IDLE);
    assign drv_event  = scl_fall | start_det | stop_det;

    // Serial engine; stop and start outrank clock edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            kind_ff   <= K_DEV;
            bitcnt_ff <= BIT_ZERO;
            shreg_ff  <= 8'h00;
            txreg_ff  <= 8'h00;
            rw_ff     <= 1'b0;
            mack_ff   <= 1'b0;
            oe_n_ff   <= 1'b1;
        end else if (stop_det) begin
            state_ff <= ST_IDLE;                                 // [R18]
            oe_n_ff  <= 1'b1;
        end else if (start_det) begin
            state_ff  <= ST_RX;                                  // [R11]
            kind_ff   <= K_DEV;
            bitcnt_ff <= BIT_ZERO;
            oe_n_ff   <= 1'b1;
        end else if (scl_rise) begin
            case (state_ff)
                ST_RX: begin
                    shreg_ff  <= {shreg_ff[6:0], sda_s2_ff};     // [R4] [R14]
                    bitcnt_ff <= bitcnt_ff + BIT_ONE;
                end
                ST_TX_ACK: begin
                    mack_ff <= ~sda_s2_ff;                       // [R17]
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_ff)
                ST_RX: begin
                    if (bitcnt_ff == BITS_PER_BYTE) begin
                        // Protected data bytes still get their ack
                        if ((kind_ff != K_DEV) || sel_match) begin // [R19]
                            state_ff <= ST_RX_ACK;
                            oe_n_ff  <= 1'b0;
                            if (kind_ff == K_DEV) begin
                                rw_ff <= shreg_ff[RW_BIT];       // [R15]
                            end
                        end else begin
                            state_ff <= ST_IDLE;                 // [R1]
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (load_tx) begin
                        state_ff  <= ST_TX;
                        txreg_ff  <= {mem_rd[6:0], 1'b0};
                        oe_n_ff   <= mem_rd[7];                  // [R4]
                        bitcnt_ff <= BIT_ONE;
                    end else begin
                        state_ff  <= ST_RX;
                        oe_n_ff   <= 1'b1;
                        bitcnt_ff <= BIT_ZERO;
                        case (kind_ff)
                            K_DEV:   kind_ff <= K_AHI;           // [R8]
                            K_AHI:   kind_ff <= K_ALO;
                            default: kind_ff <= K_DATA;
                        endcase
                    end
                end
                ST_TX: begin
                    if (bitcnt_ff == BITS_PER_BYTE) begin
                        state_ff <= ST_TX_ACK;
                        oe_n_ff  <= 1'b1;
                    end else begin
                        oe_n_ff   <= txreg_ff[7];                // [R14]
                        txreg_ff  <= {txreg_ff[6:0], 1'b0};
                        bitcnt_ff <= bitcnt_ff + BIT_ONE;
                    end
                end
                ST_TX_ACK: begin
                    if (load_tx) begin
                        state_ff  <= ST_TX;
                        txreg_ff  <= {mem_rd[6:0], 1'b0};
                        oe_n_ff   <= mem_rd[7];
                        bitcnt_ff <= BIT_ONE;
                    end else begin
                        // Master held back its ack: stay off the wire
                        state_ff <= ST_IDLE;                     // [R17]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Address latch; upper three received bits are dropped [R8] [R9]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ahi_ff  <= '0;
            addr_ff <= ADDR_ZERO;
        end else if (byte_done && (kind_ff == K_AHI)) begin
            ahi_ff <= shreg_ff[AHI_W-1:0];                       // [R9]
        end else if (byte_done && (kind_ff == K_ALO)) begin
            addr_ff <= {ahi_ff, shreg_ff};                       // [R8]
        end else if (addr_inc) begin
            addr_ff <= nxt_addr;                                 // [R16]
        end
    end

    // Array; no reset so it maps to plain storage [R7]
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem_ff[addr_ff] <= shreg_ff;                         // [R10]
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_byte_in;
        scl_fall && (state_ff == ST_RX) && (bitcnt_ff == BITS_PER_BYTE);
    endsequence

    sequence s_dev_miss;
        s_byte_in ##0 ((kind_ff == K_DEV) && !sel_match);
    endsequence

    sequence s_read_nack;
        scl_fall && (state_ff == ST_TX_ACK) && !mack_ff;
    endsequence

    a_pull_low_only: assert property ( // [R3]
        !sda_oe_n |-> (state_ff == ST_RX_ACK) || (state_ff == ST_TX))
        else $error("data wire pulled outside ack or send phase");

    a_drive_on_fall: assert property ( // [R4]
        (sda_oe_n != $past(sda_oe_n)) |-> $past(drv_event))
        else $error("data drive changed away from a falling clock");

    a_stop_abort: assert property ( // [R18]
        stop_det |=> (state_ff == ST_IDLE) && sda_oe_n)
        else $error("stop did not return the engine to idle");

    a_start_ready: assert property ( // [R11]
        start_det && !stop_det |=> (state_ff == ST_RX) && (kind_ff == K_DEV)
                                   && (bitcnt_ff == BIT_ZERO))
        else $error("start did not open a new address byte");

    a_select_miss: assert property ( // [R1]
        s_dev_miss |=> ((state_ff == ST_IDLE) && sda_oe_n) [*2])
        else $error("unselected device answered");

    a_read_nack_end: assert property ( // [R17]
        s_read_nack |=> (state_ff == ST_IDLE) && sda_oe_n)
        else $error("read went on after missing master ack");

    a_write_now: assert property ( // [R10]
        commit && !wp_s2_ff |=> mem_ff[$past(addr_ff)] == $past(shreg_ff))
        else $error("data byte not written on its ack edge");

    a_protect_hold: assert property ( // [R5]
        commit && wp_s2_ff |=> mem_ff[$past(addr_ff)] == $past(mem_rd))
        else $error("protected location was modified");

    a_protect_ack: assert property ( // [R19]
        s_byte_in ##0 (kind_ff == K_DATA) |=> !sda_oe_n
                                              && (state_ff == ST_RX_ACK))
        else $error("data byte not acknowledged");

    a_addr_wrap: assert property ( // [R16]
        addr_inc && (addr_ff == ADDR_MAX) |=> addr_ff == ADDR_ZERO)
        else $error("address latch did not wrap to zero");

endmodule : fsl_fram_slave

//--- verif/fsl_master_bfm.sv
// Two-wire bus master model: drives the serial clock and the data pull-down.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
module fsl_master_bfm (
    input  wire logic mclk,  // System clock, paces the link
    input  wire logic sda,   // Resolved data wire
    output logic      scl,   // Serial clock, high between frames
    output logic      sda_m  // Low pulls the wire, high releases
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles with both lines high
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    // One bit: data set while clock low, wire sampled mid high phase
    task automatic bit_cycle(input logic b, output logic s);
        repeat (4) @(negedge mclk);
        sda_m = b;
        @(negedge mclk);
        scl = 1'b1;
        repeat (3) @(negedge mclk);
        s = sda;
        repeat (2) @(negedge mclk);
        scl = 1'b0;
    endtask : bit_cycle

    // Start or repeated start; waits out the slave's release first
    task automatic send_start();
        @(negedge mclk);
        sda_m = 1'b1;
        repeat (4) @(negedge mclk);
        scl = 1'b1;
        repeat (5) @(negedge mclk);
        sda_m = 1'b0;
        repeat (5) @(negedge mclk);
        scl = 1'b0;
    endtask : send_start

    // Stop; clock then stands still high
    task automatic send_stop();
        repeat (4) @(negedge mclk);
        sda_m = 1'b0;
        @(negedge mclk);
        scl = 1'b1;
        repeat (5) @(negedge mclk);
        sda_m = 1'b1;
        repeat (5) @(negedge mclk);
    endtask : send_stop

    // Byte out MSB first, then the slave's acknowledge (low = ack)
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, ack);
    endtask : put_byte

    // Byte in MSB first; acknowledge only when more bytes are wanted
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
        bit_cycle(!more, s);
    endtask : get_byte
endmodule : fsl_master_bfm

//--- verif/tb.sv
// Self-checking bench for the serial memory slave, against an array model.
// Assumes the master model in fsl_master_bfm and pull-downs on the straps.
module tb import fsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary type code

    logic        mclk;
    logic        rst_n;
    logic        wp_drv;
    logic [2:0]  sel_drv;
    tri0         wp_pin;
    tri0  [2:0]  sel_pin;
    wire         scl;
    wire         sda_m;
    logic        sda_out;
    logic        sda_oe_n;
    logic        bus_active;
    int          bad_count;
    int          check_count;
    int          seed;
    int          cur;
    int          s;
    logic        k;
    logic [12:0] a;
    logic [7:0]  mdl [int];

    // Pad pull-downs and a wired-AND data line with pull-up
    assign wp_pin  = wp_drv;
    assign sel_pin = sel_drv;
    wire   sda     = sda_m & (sda_oe_n | sda_out);

    always #4 mclk = ~mclk;

    fsl_fram_slave #(.DEV_TYPE(TYPE_ID)) i_dut (.mclk(mclk), .rst_n(rst_n), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .device_select_pins(sel_pin), .wp(wp_pin), .bus_active(bus_active));

    fsl_master_bfm i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));

    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic start_dev(input logic rw, output logic ack);
        i_mst.send_start();
        i_mst.put_byte({TYPE_ID, sel_pin, rw}, ack);
    endtask : start_dev

    // Load the latch; the three spare high bits are random junk
    task automatic set_addr(input logic [12:0] ad);
        logic [7:0] r;
        r = 8'($random(seed));
        start_dev(1'b0, k);
        check("dev_ack", k, 0);
        i_mst.put_byte({r[7:5], ad[12:8]}, k);
        check("hi_ack", k, 0);
        i_mst.put_byte(ad[7:0], k);
        check("lo_ack", k, 0);
        cur = int'(ad);
    endtask : set_addr

    // Stop, then the engine must go idle with the wire released
    task automatic end_xfer();
        i_mst.send_stop();
        for (int i = 0; i < 8 && bus_active !== 1'b0; i++) @(negedge mclk);
        check("idle", {bus_active, sda_oe_n, sda_out}, 3'b010);
        if (bus_active !== 1'b0) print_verdict();
    endtask : end_xfer

    task automatic wr(input logic [12:0] ad, input int n);
        logic [7:0] d;
        set_addr(ad);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            i_mst.put_byte(d, k);
            check("data_ack", k, 0);
            if (wp_pin !== 1'b1) mdl[cur] = d; // Protected bytes leave the model alone
            cur = (cur + 1) % MEM_DEPTH; // Latch steps and wraps
        end
        end_xfer();
    endtask : wr

    // Random read when ra is set, else read from the current address
    task automatic rd(input logic ra, input logic [12:0] ad, input int n);
        logic [7:0] d;
        if (ra) set_addr(ad);
        start_dev(1'b1, k);
        check("rd_ack", k, 0);
        for (int i = 0; i < n; i++) begin
            i_mst.get_byte(i < n - 1, d);
            check("rd_data", d, mdl[cur]);
            cur = (cur + 1) % MEM_DEPTH;
        end
        end_xfer();
    endtask : rd

    // Hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        mclk        = 1'b0;
        rst_n       = 1'b0;
        wp_drv      = 1'bz;
        sel_drv     = 3'bzzz;
        bad_count   = 0;
        check_count = 0;
        seed        = 32'h6828937d;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        // Floating straps, burst across the top, back-to-back reads
        wr(13'h1FFE, 4);
        rd(1'b1, 13'h1FFE, 3);
        rd(1'b0, 13'h0000, 1);
        // Random straps: only the matching select answers
        sel_drv = 3'($random(seed));
        for (s = 0; s < 8; s++) begin
            i_mst.send_start();
            i_mst.put_byte({TYPE_ID, 3'(s), 1'b0}, k);
            check("sel_ack", k, 16'(3'(s) !== sel_pin));
            end_xfer();
        end
        // Foreign device type TYPE_ID ^ 4'h3 is not acknowledged
        i_mst.send_start();
        i_mst.put_byte({TYPE_ID ^ 4'h3, sel_pin, 1'b0}, k);
        check("type_ack", k, 1);
        end_xfer();
        // Protected burst: acked and advanced, array untouched
        wp_drv = 1'b1;
        wr(13'h1FFF, 2);
        wp_drv = 1'b0;
        rd(1'b0, 13'h0000, 1);
        rd(1'b1, 13'h1FFF, 2);
        // Stop after the high byte: latch keeps its value
        start_dev(1'b0, k);
        check("cut_dev_ack", k, 0);
        i_mst.put_byte(8'h00, k);
        check("cut_hi_ack", k, 0);
        end_xfer();
        rd(1'b0, 13'h0000, 1);
        // Random places, written then read back
        for (s = 0; s < 3; s++) begin
            a = 13'($random(seed));
            wr(a, 2);
            rd(1'b1, a, 2);
        end
        print_verdict();
    end
endmodule : tb
